/* File: hdl/adc_cal_defs.svh */
// offsets, reset values, mode codes and timing counts of the calibration controller
// assumes inclusion by bare name from the controller module
`ifndef ADC_CAL_DEFS_SVH
`define ADC_CAL_DEFS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA 8'h08
`define REG_OFFSET 8'h0C
`define REG_FSCALE 8'h10
`define REG_RAW 8'h14

// calibration mode codes
`define MODE_NORMAL 3'h0
`define MODE_SELF 3'h1
`define MODE_SYS_ZERO 3'h2
`define MODE_SYS_FULL 3'h3
`define MODE_SYS_OFS 3'h4
`define MODE_BGND 3'h5

// sequence lengths in result periods
`define LEN_SELF 4'h9
`define LEN_SYS 4'h4
`define LEN_SYS_OFS 4'h9
`define LEN_BGND 4'h6

// reset values
`define CTRL_RST 13'h1080
`define OFFSET_RST 24'h000000
`define GAIN_RST 24'h400000

// arithmetic
`define GAIN_FRAC 22
`define GAIN_MAX 24'hFFFFFF
`define FS_NUMER 46'h2000_0000_0000
`define MIDSCALE 33'h0_0080_0000
`define CODE_MAX 33'h0_00FF_FFFF
`define RAW_TOP 5'h17
`define NOTCH_MIN 5'h04
`define NOTCH_MAX 5'h17

`endif

/* File: hdl/adc_cal_pkg.sv */
// types shared by the calibration controller
// assumes the defs header is on the include path
package adc_cal_pkg;

    // control register layout, high bit first from the top
    typedef struct packed {
        logic [4:0] notch;
        logic word24;
        logic bipolar;
        logic [2:0] pga_gain;
        logic cal_mode_bit2;
        logic cal_mode_bit1;
        logic cal_mode_bit0;
    } ctrl_type;

    // node switched into the modulator
    typedef enum logic [1:0] {NODE_AIN, NODE_SHORT, NODE_REF} node_type;

    // sequencer states
    typedef enum logic [1:0] {ST_CONVERT, ST_ARM, ST_CAL} state_type;

endpackage

/* File: hdl/cal_divider.sv */
// serial restoring divider for the full-scale coefficient
// assumes start is a one-cycle pulse and den is nonzero
module cal_divider #(
    parameter int NUM_W = 46,
    parameter int DEN_W = 24
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [NUM_W-1:0] num,
    input wire logic [DEN_W-1:0] den,
    output logic done,
    output logic [NUM_W-1:0] quot
);
    localparam int CNT_W = $clog2(NUM_W + 1);

    if (NUM_W < 2 || DEN_W < 2) begin : g_chk
        $error("cal_divider widths too small");
    end

    logic [DEN_W-1:0] rem_r;
    logic [DEN_W-1:0] den_r;
    logic [CNT_W-1:0] cnt_r;
    logic [DEN_W:0] shifted;
    logic [DEN_W+1:0] trial;

    // one quotient bit per cycle
    assign shifted = {rem_r, quot[NUM_W-1]};
    assign trial = {1'b0, shifted} - {2'b00, den_r};

    // iteration and quotient shift
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        if (srst)
        begin
            rem_r <= '0;
            den_r <= '0;
            cnt_r <= '0;
            quot <= '0;
        end
        else if (start)
        begin
            rem_r <= '0;
            den_r <= den;
            cnt_r <= CNT_W'(NUM_W);
            quot <= num;
        end
        else if (cnt_r != '0)
        begin
            if (!trial[DEN_W+1])
            begin
                rem_r <= trial[DEN_W-1:0];
                quot <= {quot[NUM_W-2:0], 1'b1};
            end
            else
            begin
                rem_r <= shifted[DEN_W-1:0];
                quot <= {quot[NUM_W-2:0], 1'b0};
            end
            cnt_r <= cnt_r - 1'b1;
            done <= (cnt_r == CNT_W'(1));
        end
    end
endmodule

/* File: hdl/adc_cal_sync_ctrl.sv */
// calibration, sync and result path of a continuously converting sigma-delta converter
// assumes an APB master on CLK, a modulator bitstream pin and an async sync pin
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "adc_cal_defs.svh"

module adc_cal_sync_ctrl #(
    parameter int MOD_DIV = 256
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic SYNC_N,
    input wire logic MOD_BIT,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic RESULT_READY_N,
    output adc_cal_pkg::node_type INPUT_SEL,
    output logic [2:0] PGA_GAIN
);
    import adc_cal_pkg::*;

    if (MOD_DIV < 4 || MOD_DIV > 65536) begin : g_chk
        $error("MOD_DIV out of range");
    end

    // sequence length of a calibration mode
    function automatic logic [3:0] cal_len(input logic [2:0] m);
        case (m)
            `MODE_SELF: cal_len = `LEN_SELF;
            `MODE_SYS_ZERO: cal_len = `LEN_SYS;
            `MODE_SYS_FULL: cal_len = `LEN_SYS;
            `MODE_SYS_OFS: cal_len = `LEN_SYS_OFS;
            `MODE_BGND: cal_len = `LEN_BGND;
            default: cal_len = 4'h1;
        endcase
    endfunction

    // mode codes that start a calibration
    function automatic logic is_cal(input logic [2:0] m);
        is_cal = (m >= `MODE_SELF) && (m <= `MODE_BGND);
    endfunction

    // node converted in a given slot of a sequence
    function automatic node_type slot_node(input logic [2:0] m, input logic [3:0] s);
        slot_node = NODE_AIN;
        if ((m == `MODE_SELF || m == `MODE_BGND) && s == 4'h0)
            slot_node = NODE_SHORT;
        else if ((m == `MODE_SELF || m == `MODE_BGND || m == `MODE_SYS_OFS) && s == 4'h1)
            slot_node = NODE_REF;
    endfunction

    // slot whose conversion sets the zero point
    function automatic logic zero_slot(input logic [2:0] m, input logic [3:0] s);
        zero_slot = is_cal(m) && (m != `MODE_SYS_FULL) && (s == 4'h0);
    endfunction

    // slot whose conversion sets the full-scale point
    function automatic logic full_slot(input logic [2:0] m, input logic [3:0] s);
        if (m == `MODE_SYS_FULL)
            full_slot = (s == 4'h0);
        else
            full_slot = (m == `MODE_SELF || m == `MODE_SYS_OFS || m == `MODE_BGND)
                && (s == 4'h1);
    endfunction

    ctrl_type ctrl_r;
    state_type state_r;
    logic [2:0] mode;
    logic [2:0] sync_s_r;
    logic [2:0] mbit_s_r;
    logic sync_lvl_r;
    logic mbit_lvl_r;
    logic sync_fall_r;
    logic [15:0] div_r;
    logic mod_tick;
    logic [4:0] notch;
    logic [23:0] cnt_r;
    logic [23:0] ones_r;
    logic [23:0] conv_last;
    logic [23:0] ones_sum;
    logic [23:0] raw_r;
    logic conv_done_r;
    logic filt_rst;
    logic arm_go;
    logic cal_start_r;
    logic cal_finish;
    logic publish;
    logic [3:0] slot_r;
    logic [23:0] offset_r;
    logic [23:0] gain_r;
    logic [31:0] data_r;
    logic div_start;
    logic div_done;
    logic [45:0] div_quot;
    logic signed [24:0] span;
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [32:0] scaled;
    logic signed [32:0] biased;
    logic [23:0] code;
    logic [31:0] result_nxt;
    logic apb_done;
    logic apb_first;
    logic wr_ctrl;
    logic rd_data;
    logic mapped;
    logic [31:0] rd_mux;
    node_type sel_d_r;
    logic settle_r;
    logic settle_go;

    assign mode = {ctrl_r.cal_mode_bit2, ctrl_r.cal_mode_bit1, ctrl_r.cal_mode_bit0};
    assign PGA_GAIN = ctrl_r.pga_gain;

    // three-stage synchronisers, level moves once stages two and three agree
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sync_s_r <= 3'h7;
            mbit_s_r <= 3'h0;
            sync_lvl_r <= 1'b1;
            mbit_lvl_r <= 1'b0;
            sync_fall_r <= 1'b0;
        end
        else
        begin
            sync_s_r <= {sync_s_r[1:0], SYNC_N};
            mbit_s_r <= {mbit_s_r[1:0], MOD_BIT};
            if (sync_s_r[1] == sync_s_r[2])
                sync_lvl_r <= sync_s_r[2];
            if (mbit_s_r[1] == mbit_s_r[2])
                mbit_lvl_r <= mbit_s_r[2];
            sync_fall_r <= sync_lvl_r && (sync_s_r[1] == sync_s_r[2]) && !sync_s_r[2];
        end
    end

    // modulator tick divided straight from the master clock
    assign mod_tick = (div_r == 16'(MOD_DIV - 1));
    always_ff @(posedge CLK)
    begin
        if (SRST || mod_tick)
            div_r <= 16'h0000;
        else
            div_r <= div_r + 16'h0001;
    end

    // notch sets log2 of the decimation length
    always_comb
    begin
        notch = ctrl_r.notch;
        if (notch < `NOTCH_MIN)
            notch = `NOTCH_MIN;
        else if (notch > `NOTCH_MAX)
            notch = `NOTCH_MAX;
    end
    assign conv_last = 24'((25'h1 << notch) - 25'h1);
    assign ones_sum = ones_r + {23'h0, mbit_lvl_r};

    // filter restarts on sync, on any calibration command and on arming
    assign filt_rst = sync_fall_r || cal_start_r || arm_go || settle_go;

    // a node switch restarts the filter at the next modulator tick
    assign settle_go = mod_tick && (settle_r || (INPUT_SEL != sel_d_r));
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sel_d_r <= NODE_AIN;
            settle_r <= 1'b0;
        end
        else
        begin
            sel_d_r <= INPUT_SEL;
            if (mod_tick)
                settle_r <= 1'b0;
            else if (INPUT_SEL != sel_d_r)
                settle_r <= 1'b1;
        end
    end

    // integrate-and-dump filter, free running without any start
    always_ff @(posedge CLK)
    begin
        conv_done_r <= 1'b0;
        if (SRST || filt_rst)
        begin
            cnt_r <= 24'h000000;
            ones_r <= 24'h000000;
        end
        else if (mod_tick)
        begin
            if (cnt_r >= conv_last)
            begin
                cnt_r <= 24'h000000;
                ones_r <= 24'h000000;
                raw_r <= 24'(ones_sum << (`RAW_TOP - notch));
                conv_done_r <= 1'b1;
            end
            else
            begin
                cnt_r <= cnt_r + 24'h000001;
                ones_r <= ones_sum;
            end
        end
        if (SRST)
            raw_r <= 24'h000000;
    end

    // sequencer events
    assign arm_go = (state_r == ST_ARM) && mod_tick;
    assign publish = conv_done_r && ((state_r == ST_CONVERT)
        || ((state_r == ST_CAL) && (slot_r == cal_len(mode) - 4'h1)));
    assign cal_finish = publish && (state_r == ST_CAL) && (mode != `MODE_BGND);
    assign div_start = conv_done_r && (state_r == ST_CAL) && full_slot(mode, slot_r)
        && (span > 25'sh0);

    // calibration sequencer and input node selection
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_r <= ST_CONVERT;
            slot_r <= 4'h0;
            INPUT_SEL <= NODE_AIN;
        end
        else if (cal_start_r)
        begin
            state_r <= ST_ARM;
            slot_r <= 4'h0;
            INPUT_SEL <= slot_node(mode, 4'h0);
        end
        else
        begin
            case (state_r)
                ST_CONVERT:
                begin
                    INPUT_SEL <= NODE_AIN;
                end
                ST_ARM:
                begin
                    if (!is_cal(mode))
                        state_r <= ST_CONVERT;
                    else if (mod_tick)
                        state_r <= ST_CAL;
                end
                ST_CAL:
                begin
                    if (!is_cal(mode))
                    begin
                        state_r <= ST_CONVERT;
                        INPUT_SEL <= NODE_AIN;
                    end
                    else if (sync_fall_r)
                    begin
                        slot_r <= 4'h0;
                        INPUT_SEL <= slot_node(mode, 4'h0);
                    end
                    else if (conv_done_r)
                    begin
                        if (slot_r == cal_len(mode) - 4'h1)
                        begin
                            slot_r <= 4'h0;
                            INPUT_SEL <= slot_node(mode, 4'h0);
                            if (mode != `MODE_BGND)
                            begin
                                state_r <= ST_CONVERT;
                                INPUT_SEL <= NODE_AIN;
                            end
                        end
                        else
                        begin
                            slot_r <= slot_r + 4'h1;
                            INPUT_SEL <= slot_node(mode, slot_r + 4'h1);
                        end
                    end
                end
                default:
                begin
                    state_r <= ST_CONVERT;
                end
            endcase
        end
    end

    // span between full-scale conversion and the zero coefficient
    assign span = $signed({1'b0, raw_r}) - $signed({1'b0, offset_r});

    cal_divider #(
        .NUM_W(46),
        .DEN_W(24)
    ) u_div (
        .clk(CLK),
        .srst(SRST),
        .start(div_start),
        .num(`FS_NUMER),
        .den(span[23:0]),
        .done(div_done),
        .quot(div_quot)
    );

    // coefficients: host writes, hardware captures win on a clash
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            offset_r <= `OFFSET_RST;
            gain_r <= `GAIN_RST;
        end
        else
        begin
            if (apb_done && PWRITE && PADDR == `REG_OFFSET)
                offset_r <= PWDATA[23:0];
            if (apb_done && PWRITE && PADDR == `REG_FSCALE)
                gain_r <= PWDATA[23:0];
            if (conv_done_r && state_r == ST_CAL && zero_slot(mode, slot_r))
                offset_r <= raw_r;
            if (conv_done_r && state_r == ST_CAL && full_slot(mode, slot_r) && span <= 25'sh0)
                gain_r <= `GAIN_MAX;
            if (div_done)
                gain_r <= (div_quot > {22'h0, `GAIN_MAX}) ? `GAIN_MAX : div_quot[23:0];
        end
    end

    // offset removed first, then scaled through a 50-bit product, result at 33 bits
    always_comb
    begin
        diff = $signed({1'b0, raw_r}) - $signed({1'b0, offset_r});
        prod = diff * $signed({1'b0, gain_r});
        scaled = 33'(prod >>> `GAIN_FRAC);
        biased = ctrl_r.bipolar ? scaled + $signed(`MIDSCALE) : scaled;
        if (biased < 33'sh0)
            code = 24'h000000;
        else if (biased > $signed(`CODE_MAX))
            code = 24'hFFFFFF;
        else
            code = biased[23:0];
        result_nxt = ctrl_r.word24 ? {8'h00, code} : {16'h0000, code[23:8]};
    end

    // result register and ready flag; a new result beats a read clear
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            data_r <= 32'h00000000;
            RESULT_READY_N <= 1'b1;
        end
        else if (publish)
        begin
            data_r <= result_nxt;
            RESULT_READY_N <= 1'b0;
        end
        else if (arm_go || rd_data)
            RESULT_READY_N <= 1'b1;
    end

    // bus strobes: one wait state, effect at the completing edge
    assign apb_first = PSEL && PENABLE && !PREADY;
    assign apb_done = PSEL && PENABLE && PREADY;
    assign wr_ctrl = apb_done && PWRITE && (PADDR == `REG_CTRL);
    assign rd_data = apb_done && !PWRITE && (PADDR == `REG_DATA);

    // control register; a write beats the end-of-calibration mode clear
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ctrl_r <= `CTRL_RST;
            cal_start_r <= 1'b0;
        end
        else
        begin
            cal_start_r <= wr_ctrl && is_cal(PWDATA[2:0]);
            if (wr_ctrl)
                ctrl_r <= PWDATA[12:0];
            else if (cal_finish)
            begin
                ctrl_r.cal_mode_bit2 <= 1'b0;
                ctrl_r.cal_mode_bit1 <= 1'b0;
                ctrl_r.cal_mode_bit0 <= 1'b0;
            end
        end
    end

    // read mux and address decode
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        case (PADDR)
            `REG_CTRL: rd_mux = {19'h0, ctrl_r};
            `REG_STATUS: rd_mux = {25'h0, sync_lvl_r, slot_r, state_r != ST_CONVERT,
                RESULT_READY_N};
            `REG_DATA: rd_mux = data_r;
            `REG_OFFSET: rd_mux = {8'h00, offset_r};
            `REG_FSCALE: rd_mux = {8'h00, gain_r};
            `REG_RAW: rd_mux = {8'h00, raw_r};
            default: mapped = 1'b0;
        endcase
    end

    // bus answer registers
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end
        else
        begin
            PREADY <= apb_first;
            PSLVERR <= apb_first && !mapped;
            if (apb_first && !PWRITE)
                PRDATA <= rd_mux;
            else if (apb_done)
                PRDATA <= 32'h00000000;
        end
    end
endmodule

/* File: verification/mod_source.sv */
// modulator bitstream stand-in for the analog side of the converter
// assumes sel is the node select output of the controller
module mod_source #(
    parameter int MOD_DIV = 4
) (
    input wire logic clk,
    input wire adc_cal_pkg::node_type sel,
    input wire logic [4:0] ain_ones,
    output logic mod_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_cal_pkg::*;
    int div_r = 0;
    logic [3:0] phase_r = 4'h0;
    // one pattern step per modulator tick
    always @(posedge clk)
    begin
        div_r <= (div_r == MOD_DIV - 1) ? 0 : div_r + 1;
        if (div_r == MOD_DIV - 1)
            phase_r <= phase_r + 4'h1;
    end
    // shorted node all zeros, reference all ones, input ain_ones of each 16 ticks
    always_comb
    begin
        mod_bit = (sel == NODE_REF) | ((sel == NODE_AIN) & ({1'b0, phase_r} < ain_ones));
    end
endmodule

/* File: verification/adc_cal_sync_chk.sv */
// port checker of the calibration controller
// assumes it is bound onto adc_cal_sync_ctrl
module adc_cal_sync_chk #(
    parameter int MOD_DIV = 256
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic SYNC_N,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic RESULT_READY_N,
    input wire logic [2:0] PGA_GAIN
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_cal_pkg::*;
    localparam int CAL_RISE = MOD_DIV + 4;
    localparam int CONV_MIN = 15 * MOD_DIV;
    logic sync_d_r;
    int sync_age_r;
    logic [2:0] gain_w_r;
    logic ctrl_wr;
    logic bad_addr;
    // completed control write and unmapped address
    assign ctrl_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == 8'h00);
    assign bad_addr = (PADDR > 8'h14) || (PADDR[1:0] != 2'h0);
    // cycles since the last falling sync, gain last written
    always_ff @(posedge CLK)
    begin
        sync_d_r <= SYNC_N;
        if (ctrl_wr)
            gain_w_r <= PWDATA[5:3];
        if (SRST)
            sync_age_r <= CONV_MIN;
        else if (sync_d_r && !SYNC_N)
            sync_age_r <= 0;
        else if (sync_age_r < CONV_MIN)
            sync_age_r <= sync_age_r + 1;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    pready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held past one cycle");
    pready_wait_a: assert property (PSEL && PENABLE && $past(PSEL && !PENABLE)
        |-> !PREADY ##1 PREADY) else $error("ready not on second access cycle");
    err_with_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    unmapped_err_a: assert property (PREADY && bad_addr |-> PSLVERR)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (PREADY && !bad_addr |-> !PSLVERR)
        else $error("mapped access flagged");
    prdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    gain_follow_a: assert property (ctrl_wr |-> ##2 PGA_GAIN == gain_w_r)
        else $error("gain output not following control");
    cal_rise_a: assert property (ctrl_wr && PWDATA[2:0] inside {[3'h1:3'h5]}
        |-> ##[1:CAL_RISE] RESULT_READY_N) else $error("ready not raised by calibration");
    sync_restart_a: assert property ($fell(RESULT_READY_N) |-> sync_age_r < 6
        || sync_age_r >= CONV_MIN)
        else $error("result too soon after sync");
    cal_c: cover property (ctrl_wr && PWDATA[2:0] == 3'h1);
    sync_c: cover property (sync_d_r && !SYNC_N);
    err_c: cover property (PSLVERR);
endmodule

bind adc_cal_sync_ctrl adc_cal_sync_chk #(.MOD_DIV(MOD_DIV)) chk_i (.CLK(CLK), .SRST(SRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .SYNC_N(SYNC_N), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RESULT_READY_N(RESULT_READY_N), .PGA_GAIN(PGA_GAIN));

/* File: verification/testbench.sv */
// self-checking bench of the calibration controller over APB
// assumes the bitstream model and the bound port checker
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_cal_pkg::*;
    localparam int MD = 4;
    localparam int CONV = 16 * MD;
    localparam logic [31:0] CTL = 32'h0000_0480;
    logic clk, srst, psel, penable, pwrite, sync_n, mod_bit, pready, pslverr, rdy_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] pga;
    logic [4:0] ain;
    node_type in_sel;
    int n_mismatch = 0;
    int tests_run = 0;
    adc_cal_sync_ctrl #(.MOD_DIV(MD)) uut (.CLK(clk), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .SYNC_N(sync_n),
        .MOD_BIT(mod_bit), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RESULT_READY_N(rdy_n), .INPUT_SEL(in_sel), .PGA_GAIN(pga));
    mod_source #(.MOD_DIV(MD)) src (.clk(clk), .sel(in_sel), .ain_ones(ain), .mod_bit(mod_bit));
    task report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one APB transfer, held until ready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(pready), 32'h1);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask
    task wait_rdy(output int c);
        @(posedge clk);
        c = 1;
        while (rdy_n !== 1'b0 && c < 3000)
        begin
            @(posedge clk);
            c++;
        end
        chk(32'(c < 3000), 32'h1);
    endtask
    // start a calibration, follow the node order and the time to ready
    task cal(input logic [31:0] ctl, input int len, input logic self);
        node_type q[$];
        node_type last;
        int c;
        wr(8'h00, ctl);
        c = 0;
        last = in_sel;
        while (rdy_n !== 1'b1 && c < MD + 4)
        begin
            @(posedge clk);
            c++;
            if (in_sel !== last)
                q.push_back(in_sel);
            last = in_sel;
        end
        chk(32'(rdy_n), 32'h1);
        while (rdy_n !== 1'b0 && c < 3000)
        begin
            @(posedge clk);
            c++;
            if (in_sel !== last)
                q.push_back(in_sel);
            last = in_sel;
        end
        if (self)
        begin
            chk(32'(q[0]), 32'(NODE_SHORT));
            chk(32'(q[1]), 32'(NODE_REF));
        end
        else
            chk(32'(q.size()), 32'h0);
        chk(32'(c >= len * CONV - MD && c <= len * CONV + 2 * MD + 8), 32'h1);
    endtask
    task t_regs;
        logic [31:0] r;
        logic e;
        chk({27'h0, pga, rdy_n, in_sel}, 32'h4);
        rd_chk(8'h00, 32'h0000_1080);
        rd_chk(8'h0C, 32'h0);
        rd_chk(8'h10, 32'h0040_0000);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF, r, e);
        chk(32'(e), 32'h1);
        apb(1'b0, 8'h02, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        rd_chk(8'h00, 32'h0000_1080);
    endtask
    task t_conv;
        int c;
        logic [31:0] r;
        logic e;
        wr(8'h00, CTL);
        wr(8'h0C, 32'h0010_0000);
        wr(8'h10, 32'h0020_0000);
        ain <= 5'h08;
        wait_rdy(c);
        apb(1'b0, 8'h08, 32'h0, r, e);
        wait_rdy(c);
        chk(32'(c <= CONV), 32'h1);
        rd_chk(8'h14, 32'h0040_0000);
        rd_chk(8'h08, 32'h0018_0000);
        @(posedge clk);
        chk(32'(rdy_n), 32'h1);
        wr(8'h00, CTL & 32'hFFFF_FF7F);
        wait_rdy(c);
        rd_chk(8'h14, 32'h0040_0000);
        wait_rdy(c);
        rd_chk(8'h08, 32'h0000_1800);
    endtask
    task t_sys;
        ain <= 5'h02;
        cal(CTL | 32'h2, 4, 1'b0);
        rd_chk(8'h0C, 32'h0010_0000);
        ain <= 5'h0A;
        cal(CTL | 32'h3, 4, 1'b0);
        rd_chk(8'h10, 32'h0080_0000);
        ain <= 5'h04;
        cal(CTL | 32'h2, 4, 1'b0);
        rd_chk(8'h0C, 32'h0020_0000);
        rd_chk(8'h10, 32'h0080_0000);
        rd_chk(8'h00, CTL);
    endtask
    task t_self;
        cal(CTL | 32'h19, 9, 1'b1);
        chk(32'(pga), 32'h3);
        rd_chk(8'h0C, 32'h0);
        rd_chk(8'h10, 32'h0040_0000);
    endtask
    task t_bgnd;
        int c;
        cal(CTL | 32'h5, 6, 1'b1);
        rd_chk(8'h08, 32'h0020_0000);
        wait_rdy(c);
        chk(32'(c > 5 * CONV && c <= 6 * CONV + 3 * MD), 32'h1);
        rd_chk(8'h00, CTL | 32'h5);
        wr(8'h00, CTL);
    endtask
    task t_sync;
        int c;
        wait_rdy(c);
        rd_chk(8'h14, 32'h0020_0000);
        rd_chk(8'h08, 32'h0020_0000);
        wait_rdy(c);
        sync_n <= 1'b0;
        rd_chk(8'h08, 32'h0020_0000);
        wait_rdy(c);
        sync_n <= 1'b1;
        chk(32'(c >= CONV - MD && c <= CONV + 2 * MD + 8), 32'h1);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
    initial
    begin
        {srst, psel, penable, pwrite, paddr, pwdata, sync_n, ain} = {4'h8, 40'h0, 1'b1, 5'h0};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_conv;
        t_sys;
        t_self;
        t_bgnd;
        t_sync;
        report_and_stop;
    end
endmodule
